// File: brxc_defs.svh
`ifndef BRXC_DEFS_SVH
`define BRXC_DEFS_SVH
`define BRXC_XLEN            32
`define BRXC_NUM_GPR         31
`define BRXC_NUM_PSR         6
`define BRXC_NUM_VISIBLE     16
`define BRXC_IDX_SP          4'hD
`define BRXC_IDX_LR          4'hE
`define BRXC_IDX_PC          4'hF
`define BRXC_SW_N            31
`define BRXC_SW_Z            30
`define BRXC_SW_C            29
`define BRXC_SW_V            28
`define BRXC_SW_IRQ_DIS      7
`define BRXC_SW_FIQ_DIS      6
`define BRXC_SW_STATE        5
`define BRXC_SW_MODE_HI      4
`define BRXC_SW_MODE_LO      0
`define BRXC_SW_MASK         32'hF00000FF
`define BRXC_CODE_USER       5'h10
`define BRXC_CODE_FAST       5'h11
`define BRXC_CODE_IRQ        5'h12
`define BRXC_CODE_SUPER      5'h13
`define BRXC_CODE_ABORT      5'h17
`define BRXC_CODE_UNDEF      5'h1B
`define BRXC_CODE_SYSTEM     5'h1F
`define BRXC_SW_RESET        32'h000000D3
`define BRXC_VEC_RESET       32'h00000000
`define BRXC_VEC_UNDEF       32'h00000004
`define BRXC_VEC_TRAP        32'h00000008
`define BRXC_VEC_ABORT       32'h00000010
`define BRXC_VEC_IRQ         32'h00000018
`define BRXC_VEC_FAST        32'h0000001C
`define BRXC_INSN_FULL       32'h00000004
`define BRXC_INSN_COMPACT    32'h00000002
`endif

// File: brxc_pkg.sv
package brxc_pkg;
  typedef enum logic [2:0]
  {
    BRXC_MODE_USER   = 3'h0,
    BRXC_MODE_FAST   = 3'h1,
    BRXC_MODE_IRQ    = 3'h3,
    BRXC_MODE_SUPER  = 3'h2,
    BRXC_MODE_ABORT  = 3'h6,
    BRXC_MODE_UNDEF  = 3'h7,
    BRXC_MODE_SYSTEM = 3'h5
  } brxc_mode_t;

  typedef enum logic [2:0]
  {
    BRXC_EXC_NONE  = 3'h0,
    BRXC_EXC_ABORT = 3'h1,
    BRXC_EXC_FAST  = 3'h2,
    BRXC_EXC_IRQ   = 3'h3,
    BRXC_EXC_UNDEF = 3'h4,
    BRXC_EXC_TRAP  = 3'h5
  } brxc_exc_t;

  typedef enum logic [1:0]
  {
    BRXC_SIZE_BYTE = 2'h0,
    BRXC_SIZE_HALF = 2'h1,
    BRXC_SIZE_WORD = 2'h2
  } brxc_size_t;
endpackage

// File: brxc_exc_arb.sv
`timescale 1ns/1ps
`include "brxc_defs.svh"
module brxc_exc_arb
(
  input  wire logic               abort_req,
  input  wire logic               fast_req,
  input  wire logic               irq_req,
  input  wire logic               undef_req,
  input  wire logic               trap_req,
  input  wire logic [31:0]        status_word,
  output brxc_pkg::brxc_exc_t     winner
);
  // Fixed priority; masked interrupts wait, undef wins over trap when both occur
  always_comb
  begin
    winner = brxc_pkg::BRXC_EXC_NONE;
    if (abort_req)
      winner = brxc_pkg::BRXC_EXC_ABORT;
    else if (fast_req && !status_word[`BRXC_SW_FIQ_DIS])
      winner = brxc_pkg::BRXC_EXC_FAST;
    else if (irq_req && !status_word[`BRXC_SW_IRQ_DIS])
      winner = brxc_pkg::BRXC_EXC_IRQ;
    else if (undef_req)
      winner = brxc_pkg::BRXC_EXC_UNDEF;
    else if (trap_req)
      winner = brxc_pkg::BRXC_EXC_TRAP;
  end
endmodule // brxc_exc_arb

// File: brxc_core_regs.sv
`timescale 1ns/1ps
`include "brxc_defs.svh"
// Behaviour
// - State bit picks 32- or 16-bit instructions
// - Byte, half and word data sizes
// - Seven modes; all but user privileged
// - 31 general plus 6 status registers
// - Sixteen registers visible, chosen by mode
// - Index 15 reads as program counter
// - Call writes return address to index 14
// - Indices 0-7 shared in every mode
// - Indices 8-14 banked by current mode
// - Fast interrupt banks indices 8-12 privately
// - Every exception mode banks indices 13, 14
// - System mode uses user registers, privileged
// - Status word: flags, disables, state, mode
// - Each exception mode saves status word
// - Five exception classes, each own mode
// - Entry saves link and status in target
// - Link locates faulting instruction and return
// - Return restores status word and counter
// - Software or exceptions change the mode
// - Simultaneous exception requests are arbitrated
// - Compact state shares registers 0-7
module brxc_core_regs
#(
  parameter int XLEN = `BRXC_XLEN
)
(
  input  wire logic                   CLK,
  input  wire logic                   SRST,
  input  wire logic [3:0]             RD_A_IDX,
  input  wire logic [3:0]             RD_B_IDX,
  output logic      [XLEN-1:0]        RD_A_DATA,
  output logic      [XLEN-1:0]        RD_B_DATA,
  input  wire logic                   WR_EN,
  input  wire logic [3:0]             WR_IDX,
  input  wire logic [XLEN-1:0]        WR_DATA,
  input  wire logic                   WR_USER_BANK,
  input  wire logic                   ADVANCE,
  input  wire logic                   BRANCH_EN,
  input  wire logic [XLEN-1:0]        BRANCH_TARGET,
  input  wire logic                   CALL_EN,
  input  wire logic                   FLAGS_EN,
  input  wire logic [3:0]             FLAGS_IN,
  input  wire logic                   STATUS_WR_EN,
  input  wire logic                   STATUS_WR_CTRL,
  input  wire logic [XLEN-1:0]        STATUS_WR_DATA,
  input  wire logic                   SAVED_WR_EN,
  input  wire logic [XLEN-1:0]        SAVED_WR_DATA,
  input  wire logic                   EXC_RETURN,
  input  wire logic                   ABORT_REQ,
  input  wire logic                   FAST_REQ,
  input  wire logic                   IRQ_REQ,
  input  wire logic                   UNDEF_REQ,
  input  wire logic                   TRAP_REQ,
  input  wire logic [1:0]             ACCESS_SIZE,
  input  wire logic [XLEN-1:0]        STORE_DATA,
  output logic      [XLEN-1:0]        STORE_LANES,
  output logic      [3:0]             BYTE_EN,
  output logic      [XLEN-1:0]        PC,
  output logic      [XLEN-1:0]        CURRENT_STATUS_WORD,
  output logic      [XLEN-1:0]        SAVED_STATUS_WORD,
  output logic                        COMPACT_STATE,
  output logic                        PRIVILEGED,
  output logic                        MODE_INVALID,
  output logic                        EXC_TAKEN,
  output logic      [2:0]             EXC_CLASS
);
  if (XLEN != 32)
  begin : g_xlen_check
    $error("brxc_core_regs supports only 32-bit data");
  end

  typedef struct packed
  {
    logic [7:0][XLEN-1:0]  low;       // Shared 0-7
    logic [4:0][XLEN-1:0]  hi_main;   // 8-12 for all but fast
    logic [4:0][XLEN-1:0]  hi_fast;   // 8-12 fast private
    logic [5:0][XLEN-1:0]  sp;        // 13: user/sys, fast, irq, super, abort, undef
    logic [5:0][XLEN-1:0]  lr;        // 14, same banking
    logic [XLEN-1:0]       pc;
    logic [XLEN-1:0]       cur;
    logic [4:0][XLEN-1:0]  saved;     // fast, irq, super, abort, undef
    logic                  exc;
    logic [2:0]            cls;
    logic [XLEN-1:0]       rda;
    logic [XLEN-1:0]       rdb;
  } brxc_state_t;

  brxc_state_t         st_r;
  brxc_state_t         st_nxt;
  brxc_pkg::brxc_exc_t winner;

  function automatic brxc_pkg::brxc_mode_t decode_mode(input logic [4:0] code);
    case (code)
      `BRXC_CODE_USER:   decode_mode = brxc_pkg::BRXC_MODE_USER;
      `BRXC_CODE_FAST:   decode_mode = brxc_pkg::BRXC_MODE_FAST;
      `BRXC_CODE_IRQ:    decode_mode = brxc_pkg::BRXC_MODE_IRQ;
      `BRXC_CODE_SUPER:  decode_mode = brxc_pkg::BRXC_MODE_SUPER;
      `BRXC_CODE_ABORT:  decode_mode = brxc_pkg::BRXC_MODE_ABORT;
      `BRXC_CODE_UNDEF:  decode_mode = brxc_pkg::BRXC_MODE_UNDEF;
      `BRXC_CODE_SYSTEM: decode_mode = brxc_pkg::BRXC_MODE_SYSTEM;
      // Unused codes fall back to user banking so no state is corrupted
      default:           decode_mode = brxc_pkg::BRXC_MODE_USER;
    endcase
  endfunction

  // Bank slot for 13/14: 0 is shared by user and system
  function automatic logic [2:0] bank_of(input brxc_pkg::brxc_mode_t m);
    case (m)
      brxc_pkg::BRXC_MODE_FAST:  bank_of = 3'h1;
      brxc_pkg::BRXC_MODE_IRQ:   bank_of = 3'h2;
      brxc_pkg::BRXC_MODE_SUPER: bank_of = 3'h3;
      brxc_pkg::BRXC_MODE_ABORT: bank_of = 3'h4;
      brxc_pkg::BRXC_MODE_UNDEF: bank_of = 3'h5;
      default:                   bank_of = 3'h0;
    endcase
  endfunction

  function automatic logic [XLEN-1:0] read_reg(input brxc_state_t s, input logic [3:0] idx,
                                               input brxc_pkg::brxc_mode_t m,
                                               input logic [XLEN-1:0] pc_ahead);
    logic [2:0] b;
    b = bank_of(m);
    if (idx < 4'h8)
      read_reg = s.low[idx[2:0]];
    else if (idx < `BRXC_IDX_SP)
      read_reg = (m == brxc_pkg::BRXC_MODE_FAST) ? s.hi_fast[3'(idx - 4'h8)]
                                                 : s.hi_main[3'(idx - 4'h8)];
    else if (idx == `BRXC_IDX_SP)
      read_reg = s.sp[b];
    else if (idx == `BRXC_IDX_LR)
      read_reg = s.lr[b];
    else
      read_reg = pc_ahead;
  endfunction

  function automatic logic [2:0] saved_slot(input brxc_pkg::brxc_mode_t m);
    saved_slot = 3'(bank_of(m) - 3'h1);
  endfunction

  brxc_exc_arb u_arb
  (
    .abort_req   (ABORT_REQ),
    .fast_req    (FAST_REQ),
    .irq_req     (IRQ_REQ),
    .undef_req   (UNDEF_REQ),
    .trap_req    (TRAP_REQ),
    .status_word (st_r.cur),
    .winner      (winner)
  );

  always_comb
  begin
    brxc_pkg::brxc_mode_t cm;
    brxc_pkg::brxc_mode_t wm;
    brxc_pkg::brxc_mode_t tm;
    logic [XLEN-1:0]      step;
    logic [XLEN-1:0]      ahead;
    logic [XLEN-1:0]      link;
    logic [XLEN-1:0]      vec;
    logic [4:0]           tcode;
    logic [2:0]           wb;
    logic                 has_saved;
    tm = brxc_pkg::BRXC_MODE_USER;
    link = '0;
    vec = '0;
    tcode = '0;
    st_nxt = st_r;
    cm = decode_mode(st_r.cur[`BRXC_SW_MODE_HI:`BRXC_SW_MODE_LO]);
    step = st_r.cur[`BRXC_SW_STATE] ? `BRXC_INSN_COMPACT : `BRXC_INSN_FULL;
    // Pipeline view: operand reads of 15 see two instructions ahead
    ahead = st_r.pc + step + step;
    has_saved = (bank_of(cm) != 3'h0);
    st_nxt.exc = 1'b0;
    st_nxt.rda = read_reg(st_r, RD_A_IDX, cm, ahead);
    st_nxt.rdb = read_reg(st_r, RD_B_IDX, cm, ahead);
    // Register write; user-bank option serves load-multiple of user registers
    wm = WR_USER_BANK ? brxc_pkg::BRXC_MODE_USER : cm;
    wb = bank_of(wm);
    if (WR_EN)
    begin
      if (WR_IDX < 4'h8)
        st_nxt.low[WR_IDX[2:0]] = WR_DATA;
      else if (WR_IDX < `BRXC_IDX_SP)
      begin
        if (wm == brxc_pkg::BRXC_MODE_FAST)
          st_nxt.hi_fast[3'(WR_IDX - 4'h8)] = WR_DATA;
        else
          st_nxt.hi_main[3'(WR_IDX - 4'h8)] = WR_DATA;
      end
      else if (WR_IDX == `BRXC_IDX_SP)
        st_nxt.sp[wb] = WR_DATA;
      else if (WR_IDX == `BRXC_IDX_LR)
        st_nxt.lr[wb] = WR_DATA;
    end
    if (CALL_EN)
      st_nxt.lr[bank_of(cm)] = st_r.pc + step;
    if (FLAGS_EN)
      st_nxt.cur[`BRXC_SW_N:`BRXC_SW_V] = FLAGS_IN;
    // User mode may change only flags; control byte needs privilege
    if (STATUS_WR_EN)
    begin
      st_nxt.cur[`BRXC_SW_N:`BRXC_SW_V] = STATUS_WR_DATA[`BRXC_SW_N:`BRXC_SW_V];
      if (STATUS_WR_CTRL && cm != brxc_pkg::BRXC_MODE_USER)
        st_nxt.cur[7:0] = STATUS_WR_DATA[7:0];
    end
    if (SAVED_WR_EN && has_saved)
      st_nxt.saved[saved_slot(cm)] = SAVED_WR_DATA & `BRXC_SW_MASK;
    if (WR_EN && WR_IDX == `BRXC_IDX_PC)
      st_nxt.pc = WR_DATA;
    else if (BRANCH_EN)
      st_nxt.pc = BRANCH_TARGET;
    else if (ADVANCE)
      st_nxt.pc = st_r.pc + step;
    // Return: link value in the counter, saved word back into the status word
    if (EXC_RETURN && has_saved)
    begin
      st_nxt.cur = st_r.saved[saved_slot(cm)];
      st_nxt.pc = st_r.lr[bank_of(cm)];
    end
    // Exception entry overrides the counter, mode, state, IRQ-disable, target link and target saved word issued this cycle,
    // and FIQ-disable on fast or abort entry; other register and flag writes still apply
    if (winner != brxc_pkg::BRXC_EXC_NONE)
    begin
      case (winner)
        brxc_pkg::BRXC_EXC_ABORT:
        begin
          tm = brxc_pkg::BRXC_MODE_ABORT; tcode = `BRXC_CODE_ABORT; vec = `BRXC_VEC_ABORT;
        end
        brxc_pkg::BRXC_EXC_FAST:
        begin
          tm = brxc_pkg::BRXC_MODE_FAST; tcode = `BRXC_CODE_FAST; vec = `BRXC_VEC_FAST;
        end
        brxc_pkg::BRXC_EXC_IRQ:
        begin
          tm = brxc_pkg::BRXC_MODE_IRQ; tcode = `BRXC_CODE_IRQ; vec = `BRXC_VEC_IRQ;
        end
        brxc_pkg::BRXC_EXC_UNDEF:
        begin
          tm = brxc_pkg::BRXC_MODE_UNDEF; tcode = `BRXC_CODE_UNDEF; vec = `BRXC_VEC_UNDEF;
        end
        default:
        begin
          tm = brxc_pkg::BRXC_MODE_SUPER; tcode = `BRXC_CODE_SUPER; vec = `BRXC_VEC_TRAP;
        end
      endcase
      // Link is the next instruction; handler adjusts to find the culprit
      link = st_r.pc + step;
      st_nxt.lr[bank_of(tm)] = link;
      st_nxt.saved[saved_slot(tm)] = st_r.cur & `BRXC_SW_MASK;
      st_nxt.cur[`BRXC_SW_MODE_HI:`BRXC_SW_MODE_LO] = tcode;
      st_nxt.cur[`BRXC_SW_STATE] = 1'b0;
      st_nxt.cur[`BRXC_SW_IRQ_DIS] = 1'b1;
      if (tm == brxc_pkg::BRXC_MODE_FAST || tm == brxc_pkg::BRXC_MODE_ABORT)
        st_nxt.cur[`BRXC_SW_FIQ_DIS] = st_r.cur[`BRXC_SW_FIQ_DIS] |
                                       (tm == brxc_pkg::BRXC_MODE_FAST);
      st_nxt.pc = vec;
      st_nxt.exc = 1'b1;
      st_nxt.cls = winner;
    end
    st_nxt.cur = st_nxt.cur & `BRXC_SW_MASK;
    if (SRST)
    begin
      st_nxt = '0;
      st_nxt.cur = `BRXC_SW_RESET;
      st_nxt.pc = `BRXC_VEC_RESET;
    end
  end

  always_ff @(posedge CLK)
  begin
    st_r <= st_nxt;
  end

  // Byte lanes: narrow stores replicated, enables from address-free size only
  always_comb
  begin
    case (brxc_pkg::brxc_size_t'(ACCESS_SIZE))
      brxc_pkg::BRXC_SIZE_BYTE:
      begin
        STORE_LANES = {4{STORE_DATA[7:0]}};
        BYTE_EN = 4'h1;
      end
      brxc_pkg::BRXC_SIZE_HALF:
      begin
        STORE_LANES = {2{STORE_DATA[15:0]}};
        BYTE_EN = 4'h3;
      end
      default:
      begin
        STORE_LANES = STORE_DATA;
        BYTE_EN = 4'hF;
      end
    endcase
  end

  always_comb
  begin
    brxc_pkg::brxc_mode_t om;
    om = decode_mode(st_r.cur[`BRXC_SW_MODE_HI:`BRXC_SW_MODE_LO]);
    RD_A_DATA = st_r.rda;
    RD_B_DATA = st_r.rdb;
    PC = st_r.pc;
    CURRENT_STATUS_WORD = st_r.cur;
    SAVED_STATUS_WORD = (bank_of(om) != 3'h0) ? st_r.saved[saved_slot(om)] : '0;
    COMPACT_STATE = st_r.cur[`BRXC_SW_STATE];
    PRIVILEGED = (st_r.cur[4:0] != `BRXC_CODE_USER);
    MODE_INVALID = (st_r.cur[4:0] != `BRXC_CODE_USER) &&
                   (om == brxc_pkg::BRXC_MODE_USER);
    EXC_TAKEN = st_r.exc;
    EXC_CLASS = st_r.cls;
  end
endmodule // brxc_core_regs

// File: brxc_intc_model.sv
`timescale 1ns/1ps
module brxc_intc_model
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       raise_fast,
  input  wire logic       raise_irq,
  input  wire logic       exc_taken,
  input  wire logic [2:0] exc_class,
  output logic            fast_req,
  output logic            irq_req
);
  // Level requests held until the core reports taking that class
  always_ff @(posedge clk)
  begin
    fast_req <= !srst && (raise_fast || (fast_req && !(exc_taken && exc_class == 3'h2)));
    irq_req  <= !srst && (raise_irq || (irq_req && !(exc_taken && exc_class == 3'h3)));
  end
endmodule // brxc_intc_model

// File: brxc_core_regs_checker.sv
`timescale 1ns/1ps
module brxc_core_regs_checker
(
  input wire logic        CLK,
  input wire logic        SRST,
  input wire logic        ABORT_REQ,
  input wire logic        FAST_REQ,
  input wire logic        IRQ_REQ,
  input wire logic        UNDEF_REQ,
  input wire logic        TRAP_REQ,
  input wire logic        EXC_RETURN,
  input wire logic [1:0]  ACCESS_SIZE,
  input wire logic [31:0] STORE_DATA,
  input wire logic [31:0] STORE_LANES,
  input wire logic [3:0]  BYTE_EN,
  input wire logic [31:0] PC,
  input wire logic [31:0] CURRENT_STATUS_WORD,
  input wire logic [31:0] SAVED_STATUS_WORD,
  input wire logic        COMPACT_STATE,
  input wire logic        PRIVILEGED,
  input wire logic        EXC_TAKEN,
  input wire logic [2:0]  EXC_CLASS
);
  logic [31:0] csw;
  logic        quiet;
  assign csw   = CURRENT_STATUS_WORD;
  assign quiet = !(ABORT_REQ || FAST_REQ || IRQ_REQ || UNDEF_REQ || TRAP_REQ);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  property p_reset; $fell(SRST) |-> csw == 32'hD3 && PC == 32'h0; endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_abort; ABORT_REQ |=> EXC_TAKEN && EXC_CLASS == 3'h1 && PC == 32'h10
    && csw[7] && !csw[5] && csw[4:0] == 5'h17 && csw[6] == $past(csw[6]); endproperty
  a_abort: assert property (p_abort) else $error("abort entry wrong");
  property p_fast; FAST_REQ && !ABORT_REQ && !csw[6] |=> EXC_CLASS == 3'h2
    && PC == 32'h1C && csw[7:0] == 8'hD1; endproperty
  a_fast: assert property (p_fast) else $error("fast entry wrong");
  property p_irq; IRQ_REQ && !ABORT_REQ && !FAST_REQ && !csw[7] |=> EXC_CLASS == 3'h3
    && PC == 32'h18 && csw[7] && !csw[5] && csw[4:0] == 5'h12; endproperty
  a_irq: assert property (p_irq) else $error("irq entry wrong");
  property p_saved; ABORT_REQ || UNDEF_REQ || TRAP_REQ |=> EXC_TAKEN
    && SAVED_STATUS_WORD == $past(csw); endproperty
  a_saved: assert property (p_saved) else $error("saved word not captured");
  property p_masked; IRQ_REQ && csw[7] && !(ABORT_REQ || FAST_REQ || UNDEF_REQ || TRAP_REQ)
    |=> !EXC_TAKEN; endproperty
  a_masked: assert property (p_masked) else $error("masked irq taken");
  property p_quiet; quiet |=> !EXC_TAKEN; endproperty
  a_quiet: assert property (p_quiet) else $error("spurious entry");
  property p_return; EXC_RETURN && quiet && csw[4:0] == 5'h11
    |=> csw == $past(SAVED_STATUS_WORD); endproperty
  a_return: assert property (p_return) else $error("return status wrong");
  property p_user; csw[4:0] == 5'h10 |-> !PRIVILEGED ##1 (csw[4:0] == 5'h10 || EXC_TAKEN);
  endproperty
  a_user: assert property (p_user) else $error("user privilege wrong");
  property p_compact; EXC_TAKEN |-> !COMPACT_STATE && !csw[5]; endproperty
  a_compact: assert property (p_compact) else $error("state bit decode wrong");
  property p_word; ACCESS_SIZE == 2'h2 |-> BYTE_EN == 4'hF && STORE_LANES == STORE_DATA;
  endproperty
  a_word: assert property (p_word) else $error("word lanes wrong");
endmodule // brxc_core_regs_checker

bind brxc_core_regs brxc_core_regs_checker i_brxc_core_regs_checker (.*);

// File: test_banked_register_exception.sv
`timescale 1ns/1ps
module test_banked_register_exception;
  logic        CLK, SRST, WR_EN, WR_USER_BANK, ADVANCE, BRANCH_EN, CALL_EN, FLAGS_EN;
  logic        STATUS_WR_EN, STATUS_WR_CTRL, SAVED_WR_EN, EXC_RETURN, ABORT_REQ, UNDEF_REQ;
  logic        TRAP_REQ, COMPACT_STATE, PRIVILEGED, MODE_INVALID, EXC_TAKEN;
  logic        FAST_REQ, IRQ_REQ, raise_fast, raise_irq;
  logic [1:0]  ACCESS_SIZE;
  logic [2:0]  EXC_CLASS;
  logic [3:0]  RD_A_IDX, RD_B_IDX, WR_IDX, FLAGS_IN, BYTE_EN;
  logic [31:0] RD_A_DATA, RD_B_DATA, WR_DATA, BRANCH_TARGET, STATUS_WR_DATA, SAVED_WR_DATA;
  logic [31:0] STORE_DATA, STORE_LANES, PC, CURRENT_STATUS_WORD, SAVED_STATUS_WORD;
  int          num_errors, n_tests, cycles;
  wire [31:0]  csw = CURRENT_STATUS_WORD;

  brxc_core_regs i_brxc_core_regs (.*);
  brxc_intc_model i_brxc_intc_model (.clk(CLK), .srst(SRST), .raise_fast(raise_fast),
    .raise_irq(raise_irq), .exc_taken(EXC_TAKEN), .exc_class(EXC_CLASS),
    .fast_req(FAST_REQ), .irq_req(IRQ_REQ));

  initial
  begin
    CLK = 0;
    forever #2.5 CLK = ~CLK;
  end

  task report_and_stop();
    if (num_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Generous ceiling; the whole run needs under a hundred cycles
  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      report_and_stop();
    end
  end

  task chk(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(logic [3:0] i, logic [31:0] d);
    {WR_EN, WR_IDX, WR_DATA} = {1'b1, i, d};
    @(negedge CLK);
    WR_EN = 0;
    // Idle cycle keeps back-to-back strobes apart
    @(negedge CLK);
  endtask

  // Both read ports look at the same index so each is exercised
  task rd(logic [3:0] i, logic [31:0] e);
    RD_A_IDX = i;
    RD_B_IDX = i;
    @(negedge CLK);
    chk(RD_A_DATA, e);
    chk(RD_B_DATA, e);
  endtask

  task st(logic [31:0] d);
    {STATUS_WR_EN, STATUS_WR_CTRL, STATUS_WR_DATA} = {2'h3, d};
    @(negedge CLK);
    STATUS_WR_EN = 0;
    @(negedge CLK);
  endtask

  task t_reset();
    chk(csw, 32'hD3);
    chk(PC, 32'h0);
    chk(PRIVILEGED, 1);
  endtask

  task t_bank();
    wr(4'h3, 32'hA3);
    wr(4'h8, 32'hB8);
    wr(4'hD, 32'hCD);
    st(32'h1F);
    rd(4'h3, 32'hA3);
    rd(4'h8, 32'hB8);
    rd(4'hD, 32'h0);
    wr(4'hD, 32'hDD);
    {BRANCH_EN, BRANCH_TARGET} = {1'b1, 32'h40};
    @(negedge CLK);
    {BRANCH_EN, raise_fast} = 2'h1;
    @(negedge CLK);
    raise_fast = 0;
    @(negedge CLK);
    chk(PC, 32'h1C);
    chk(SAVED_STATUS_WORD, 32'h1F);
    rd(4'h3, 32'hA3);
    rd(4'h8, 32'h0);
    rd(4'hD, 32'h0);
    rd(4'hE, 32'h44);
    wr(4'h8, 32'hF8);
    WR_USER_BANK = 1;
    wr(4'h9, 32'hC9);
    WR_USER_BANK = 0;
    {SAVED_WR_EN, SAVED_WR_DATA} = {1'b1, 32'h8000001F};
    @(negedge CLK);
    SAVED_WR_EN = 0;
    chk(SAVED_STATUS_WORD, 32'h8000001F);
    EXC_RETURN = 1;
    @(negedge CLK);
    EXC_RETURN = 0;
    chk(csw, 32'h8000001F);
    chk(PC, 32'h44);
    rd(4'h8, 32'hB8);
    rd(4'h9, 32'hC9);
    rd(4'hD, 32'hDD);
  endtask

  task t_pc();
    {BRANCH_EN, BRANCH_TARGET} = {1'b1, 32'h100};
    @(negedge CLK);
    {BRANCH_EN, ADVANCE} = 2'h1;
    @(negedge CLK);
    ADVANCE = 0;
    chk(PC, 32'h104);
    rd(4'hF, 32'h10C);
    CALL_EN = 1;
    @(negedge CLK);
    {CALL_EN, FLAGS_EN, FLAGS_IN} = 6'h19;
    @(negedge CLK);
    FLAGS_EN = 0;
    chk(csw, 32'h9000001F);
    rd(4'hE, 32'h108);
    st(32'h3F);
    chk(COMPACT_STATE, 1);
    ADVANCE = 1;
    @(negedge CLK);
    ADVANCE = 0;
    rd(4'hF, 32'h10A);
    rd(4'h3, 32'hA3);
    {ACCESS_SIZE, STORE_DATA} = {2'h2, 32'h5A1C3E97}; // Aligned by software
    @(negedge CLK);
    chk(BYTE_EN, 4'hF);
    chk(STORE_LANES, 32'h5A1C3E97);
    ACCESS_SIZE = 2'h1;
    @(negedge CLK);
    chk(BYTE_EN, 4'h3);
    chk(STORE_LANES, 32'h3E973E97);
    ACCESS_SIZE = 2'h0;
    @(negedge CLK);
    chk(BYTE_EN, 4'h1);
    chk(STORE_LANES, 32'h97979797);
  endtask

  // Rows hold {abort, fast, irq, undef, trap}; the winner's class is row plus one
  task automatic t_prio();
    logic [4:0]  rq [5] = '{5'h13, 5'h0A, 5'h07, 5'h03, 5'h01};
    logic [31:0] vec [5] = '{32'h10, 32'h1C, 32'h18, 32'h4, 32'h8};
    logic [4:0]  md [5] = '{5'h17, 5'h11, 5'h12, 5'h1B, 5'h13};
    for (int i = 0; i < 5; i++)
    begin
      st(32'h1F);
      {raise_fast, raise_irq} = rq[i][3:2];
      @(negedge CLK);
      {raise_fast, raise_irq, ABORT_REQ, UNDEF_REQ, TRAP_REQ} = {2'h0, rq[i][4], rq[i][1:0]};
      @(negedge CLK);
      {ABORT_REQ, UNDEF_REQ, TRAP_REQ} = 3'h0;
      chk(EXC_TAKEN, 1);
      chk(EXC_CLASS, i + 1);
      chk(PC, vec[i]);
      chk(csw[4:0], md[i]);
      chk(SAVED_STATUS_WORD, 32'h1F);
    end
  endtask

  task t_user();
    st(32'h1E);
    chk(MODE_INVALID, 1);
    chk(SAVED_STATUS_WORD, 32'h0);
    // An unused code locks out control writes; a trap is the way back
    TRAP_REQ = 1;
    @(negedge CLK);
    TRAP_REQ = 0;
    chk(csw[4:0], 5'h13);
    st(32'h10);
    chk(PRIVILEGED, 0);
    chk(MODE_INVALID, 0);
    chk(SAVED_STATUS_WORD, 32'h0);
    st(32'h1F);
    chk(csw, 32'h10);
  endtask

  initial
  begin
    {WR_EN, WR_USER_BANK, ADVANCE, BRANCH_EN, CALL_EN, FLAGS_EN, STATUS_WR_EN} = '0;
    {STATUS_WR_CTRL, SAVED_WR_EN, EXC_RETURN, ABORT_REQ, UNDEF_REQ, TRAP_REQ} = '0;
    {raise_fast, raise_irq, ACCESS_SIZE, RD_A_IDX, RD_B_IDX, WR_IDX, FLAGS_IN} = '0;
    {WR_DATA, BRANCH_TARGET, STATUS_WR_DATA, SAVED_WR_DATA, STORE_DATA} = '0;
    {num_errors, n_tests, cycles} = '0;
    SRST = 1;
    repeat (8) @(negedge CLK);
    SRST = 0;
    t_reset();
    t_bank();
    t_pc();
    t_prio();
    t_user();
    report_and_stop();
  end
endmodule // test_banked_register_exception
